/* rtl/aclact_top.sv */
// Purpose: acl entry action bytes, cascade mask and count action for five ports
// Assumes: software writes table select, offset, then data register
// Notes: only offsets 0x0a..0x0d are held here; others read zero
`timescale 1ns/1ps
module aclact_top
  import aclact_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  input  wire logic [7:0] TABLE_SEL,
  input  wire logic [7:0] OFFSET,
  input  wire logic       DATA_WR,
  input  wire logic [7:0] DATA_IN,
  output logic      [7:0] DATA_OUT,
  input  wire logic [2:0] PKT_PORT,
  input  wire logic       PKT_VALID,
  input  wire logic       PKT_MATCH,
  input  wire logic [1:0] RULE_KIND_SELECT,
  input  wire logic [1:0] ENTRY_MATCH_SELECT,
  input  wire logic [2:0] QOS_PRI,
  input  wire logic [4:0] LUT_MAP,
  output logic      [2:0] PRI_OUT,
  output logic            REMARK_EN_OUT,
  output logic      [2:0] REMARK_VALUE_OUT,
  output logic      [4:0] MAP_OUT,
  output logic      [15:0] CASCADE_GROUP_MASK,
  output logic      [NUM_PORTS-1:0] COUNT_IRQ
);
  // ==========================================================
  // indirect byte storage
  logic [7:0] pri_act_r  [NUM_PORTS];
  logic [7:0] map_act_r  [NUM_PORTS];
  logic [7:0] mask_hi_r  [NUM_PORTS];
  logic [7:0] mask_lo_r  [NUM_PORTS];
  logic       sel_ok;
  logic [3:0] sel_port;
  logic [2:0] pidx;
  logic       us_tick;
  logic       ms_tick;

  function automatic logic port_ok(input logic [3:0] p);
    port_ok = (p >= 4'h1) && (p <= 4'(NUM_PORTS));
  endfunction

  // port number 1..5 to storage index 0..4
  function automatic logic [2:0] port_index(input logic [3:0] p);
    port_index = 3'(p - 4'h1);
  endfunction

  assign sel_port = TABLE_SEL[3:0];
  assign sel_ok   = (TABLE_SEL[7:5] == TABLE_SEL_ACL) && port_ok(sel_port);

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
          pri_act_r[g] <= RESET_BYTE;
          map_act_r[g] <= RESET_BYTE;
          mask_hi_r[g] <= RESET_BYTE;
          mask_lo_r[g] <= RESET_BYTE;
        end else if (DATA_WR && sel_ok && (sel_port == 4'(g + 1))) begin
          if (OFFSET == OFF_PRIORITY_ACT) pri_act_r[g] <= DATA_IN;
          if (OFFSET == OFF_MAP_ACT)      map_act_r[g] <= DATA_IN;
          if (OFFSET == OFF_MASK_HIGH)    mask_hi_r[g] <= DATA_IN;
          if (OFFSET == OFF_MASK_LOW)     mask_lo_r[g] <= DATA_IN;
        end
      end
    end
  endgenerate

  // ==========================================================
  // read path
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      DATA_OUT <= 8'h00;
    end else if (!sel_ok) begin
      DATA_OUT <= 8'h00;
    end else begin
      unique case (OFFSET)
        OFF_PRIORITY_ACT: DATA_OUT <= pri_act_r[port_index(sel_port)];
        OFF_MAP_ACT:      DATA_OUT <= map_act_r[port_index(sel_port)];
        OFF_MASK_HIGH:    DATA_OUT <= mask_hi_r[port_index(sel_port)];
        OFF_MASK_LOW:     DATA_OUT <= mask_lo_r[port_index(sel_port)];
        default:          DATA_OUT <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // per-packet action for the ingress port
  assign pidx = (PKT_PORT < 3'(NUM_PORTS)) ? PKT_PORT : 3'h0;

  aclact_prio u_prio (
    .pmode     (pri_act_r[pidx][PRIO_MODE_HI:PRIO_MODE_LO]),
    .entry_pri (pri_act_r[pidx][PRI_HI:PRI_LO]),
    .qos_pri   (QOS_PRI),
    .map_mode  (map_act_r[pidx][MAP_MODE_HI:MAP_MODE_LO]),
    .entry_map (map_act_r[pidx][FWD_HI:FWD_LO]),
    .lut_map   (LUT_MAP),
    .pri_out   (PRI_OUT),
    .map_out   (MAP_OUT)
  );

  assign REMARK_EN_OUT      = pri_act_r[pidx][REMARK_EN_BIT];
  assign REMARK_VALUE_OUT   = {pri_act_r[pidx][REMARK_UP_HI:REMARK_UP_LO], map_act_r[pidx][REMARK_LSB_BIT]};
  assign CASCADE_GROUP_MASK = {mask_hi_r[pidx], mask_lo_r[pidx]};

  // ==========================================================
  // count / timer action
  aclact_tick u_tick (
    .clk     (CLOCK),
    .rst_n   (RESETN),
    .us_tick (us_tick),
    .ms_tick (ms_tick)
  );

  logic count_cfg;
  assign count_cfg = (RULE_KIND_SELECT == KIND_COUNT) && (ENTRY_MATCH_SELECT == MATCH_COUNT);

  logic [10:0] cnt_r    [NUM_PORTS];
  logic        run_r    [NUM_PORTS];
  logic        irq_r    [NUM_PORTS];
  logic [10:0] limit_w  [NUM_PORTS];
  logic        tick_w   [NUM_PORTS];
  logic        hit_w    [NUM_PORTS];
  logic        down_w   [NUM_PORTS];
  logic        expire_w [NUM_PORTS];
  logic        reach_w  [NUM_PORTS];

  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_cnt
      assign limit_w[g]  = {pri_act_r[g], map_act_r[g][REMARK_LSB_BIT:MAP_MODE_LO]};
      assign tick_w[g]   = map_act_r[g][UNIT_BIT] ? ms_tick : us_tick;
      assign hit_w[g]    = PKT_VALID && PKT_MATCH && (PKT_PORT == 3'(g));
      assign down_w[g]   = !map_act_r[g][DIR_BIT];
      // down count ends on the tick that takes it past one
      assign expire_w[g] = count_cfg && down_w[g] && run_r[g] && tick_w[g] && (cnt_r[g] <= 11'h001);
      // up count ends on the match that reaches the limit
      assign reach_w[g]  = count_cfg && !down_w[g] && hit_w[g] && ((cnt_r[g] + 11'h001) >= limit_w[g]);

      // a matched packet arms the down count
      always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
          run_r[g] <= 1'b0;
        end else if (!count_cfg) begin
          run_r[g] <= 1'b0;
        end else if (down_w[g] && !run_r[g] && hit_w[g]) begin
          run_r[g] <= 1'b1;
        end else if (expire_w[g]) begin
          run_r[g] <= 1'b0;
        end
      end

      always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
          cnt_r[g] <= 11'h000;
        end else if (!count_cfg) begin
          cnt_r[g] <= 11'h000;
        end else if (down_w[g]) begin
          if (!run_r[g] && hit_w[g]) begin
            cnt_r[g] <= limit_w[g];
          end else if (expire_w[g]) begin
            cnt_r[g] <= 11'h000;
          end else if (run_r[g] && tick_w[g]) begin
            cnt_r[g] <= cnt_r[g] - 11'h001;
          end
        end else if (reach_w[g]) begin
          cnt_r[g] <= 11'h000;
        end else if (hit_w[g]) begin
          cnt_r[g] <= cnt_r[g] + 11'h001;
        end
      end

      // one-cycle pulse per finished count
      always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
          irq_r[g] <= 1'b0;
        end else begin
          irq_r[g] <= expire_w[g] || reach_w[g];
        end
      end
    end
  endgenerate

  // gather per-port pulses so the output has a single driver
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      COUNT_IRQ[i] = irq_r[i];
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  a_force_pri: assert property ((pri_act_r[pidx][7:6] == 2'b11) |-> PRI_OUT == pri_act_r[pidx][5:3])
    else $error("forced priority not applied");
  a_keep_pri: assert property ((pri_act_r[pidx][7:6] == 2'b00) |-> PRI_OUT == QOS_PRI)
    else $error("priority changed in keep mode");
  a_higher_pri: assert property ((pri_act_r[pidx][7:6] == 2'b01)
      |-> PRI_OUT == ((pri_act_r[pidx][5:3] > QOS_PRI) ? pri_act_r[pidx][5:3] : QOS_PRI))
    else $error("higher mode priority wrong");
  a_lower_pri: assert property ((pri_act_r[pidx][7:6] == 2'b10)
      |-> PRI_OUT == ((pri_act_r[pidx][5:3] < QOS_PRI) ? pri_act_r[pidx][5:3] : QOS_PRI))
    else $error("lower mode priority wrong");
  a_map_or: assert property ((map_act_r[pidx][6:5] == 2'b01) |-> MAP_OUT == (LUT_MAP | map_act_r[pidx][4:0]))
    else $error("or map wrong");
  a_map_and: assert property ((map_act_r[pidx][6:5] == 2'b10) |-> MAP_OUT == (LUT_MAP & map_act_r[pidx][4:0]))
    else $error("and map wrong");
  a_map_lut: assert property ((map_act_r[pidx][6:5] == 2'b00) |-> MAP_OUT == LUT_MAP)
    else $error("lookup map not kept");
  a_map_force: assert property ((map_act_r[pidx][6:5] == 2'b11) |-> MAP_OUT == map_act_r[pidx][4:0])
    else $error("entry map not substituted");
  a_mask_write: assert property ((DATA_WR && sel_ok && OFFSET == 8'h0d && sel_port == 4'h1)
      |=> mask_lo_r[0] == $past(DATA_IN))
    else $error("mask low byte not stored");
  a_mask_read: assert property ((sel_ok && OFFSET == OFF_MASK_HIGH)
      |=> DATA_OUT == $past(mask_hi_r[port_index(sel_port)]))
    else $error("mask high byte read wrong");
  a_read_refused: assert property (!sel_ok |=> DATA_OUT == 8'h00)
    else $error("refused selection returned data");
  a_irq_cfg: assert property (!count_cfg |=> COUNT_IRQ == '0)
    else $error("interrupt outside count mode");

  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_chk
      a_down_load: assert property ((count_cfg && down_w[g] && !run_r[g] && hit_w[g])
          |=> run_r[g] && cnt_r[g] == $past(limit_w[g]))
        else $error("down count not loaded from limit");
      a_down_step: assert property ((count_cfg && down_w[g] && run_r[g] && tick_w[g] && cnt_r[g] > 11'h001)
          |=> cnt_r[g] == $past(cnt_r[g]) - 11'h001 && !COUNT_IRQ[g])
        else $error("down count step wrong");
      a_up_reach: assert property ((count_cfg && !down_w[g] && hit_w[g] && cnt_r[g] + 11'h001 >= limit_w[g])
          |=> COUNT_IRQ[g] && cnt_r[g] == 11'h000)
        else $error("up count limit missed");
    end
  endgenerate

  c_count_irq: cover property (COUNT_IRQ != '0);
  c_mask_rd: cover property (DATA_WR && OFFSET == 8'h0c ##1 !DATA_WR && OFFSET == 8'h0c);
  c_force: cover property (pri_act_r[pidx][7:6] == 2'b11 && PKT_VALID);
  c_down_irq: cover property (count_cfg && down_w[1] && COUNT_IRQ[1]);
endmodule // aclact_top

/* inc/aclact_pkg.sv */
// Purpose: constants for the acl action and rule-set block
// Assumes: one entry per port, byte access through table/offset/data registers
// Notes:
// Function
// - mode 00 keeps classified priority
// - mode 01 uses entry priority if greater
// - mode 10 uses entry priority if smaller
// - mode 11 always uses entry priority
// - priority bits 5:3, mode bits 7:6
// - remark enable replaces vlan priority bits
// - remark value split across offsets 0a/0b
// - map mode 00 uses lookup map only
// - map mode 01 ors entry and lookup
// - map mode 10 ands entry and lookup
// - map mode 11 replaces lookup map
// - egress map bit n is port n+1
// - count mode bit 4 selects us/ms
// - bit 3 low counts down, interrupt at expiry
// - bit 3 high counts matches to limit
// - cascade mask has sixteen entry bits
// - mask high at 0c, low at 0d
package aclact_pkg;
  localparam logic [2:0] TABLE_SEL_ACL      = 3'h2;
  localparam logic [7:0] OFF_PRIORITY_ACT   = 8'h0a;
  localparam logic [7:0] OFF_MAP_ACT        = 8'h0b;
  localparam logic [7:0] OFF_MASK_HIGH      = 8'h0c;
  localparam logic [7:0] OFF_MASK_LOW       = 8'h0d;
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  localparam int         NUM_PORTS          = 5;
  localparam int         PRIO_MODE_HI       = 7;
  localparam int         PRIO_MODE_LO       = 6;
  localparam int         PRI_HI             = 5;
  localparam int         PRI_LO             = 3;
  localparam int         REMARK_EN_BIT      = 2;
  localparam int         REMARK_UP_HI       = 1;
  localparam int         REMARK_UP_LO       = 0;
  localparam int         REMARK_LSB_BIT     = 7;
  localparam int         MAP_MODE_HI        = 6;
  localparam int         MAP_MODE_LO        = 5;
  localparam int         FWD_HI             = 4;
  localparam int         FWD_LO             = 0;
  localparam int         UNIT_BIT           = 4;
  localparam int         DIR_BIT            = 3;
  localparam logic [1:0] KIND_COUNT         = 2'h1;
  localparam logic [1:0] MATCH_COUNT        = 2'h0;
  localparam int         CLK_MHZ            = 200;
  localparam int         US_NS              = 1000;
  localparam int         CLK_NS             = 1000 / CLK_MHZ;
  localparam int         US_CYCLES          = US_NS / CLK_NS;
  localparam int         MS_PER_US          = 1000;
  typedef enum logic [1:0] {
    ACLACT_KEEP = 2'b00, ACLACT_HIGHER = 2'b01, ACLACT_LOWER = 2'b10, ACLACT_FORCE = 2'b11
  } aclact_pmode_type;
endpackage

/* rtl/aclact_prio.sv */
// Purpose: priority selection and port map combining
// Assumes: qos priority and lookup map valid in same cycle
// Notes: purely combinational
`timescale 1ns/1ps
module aclact_prio
  import aclact_pkg::*;
(
  input  wire logic [1:0] pmode,
  input  wire logic [2:0] entry_pri,
  input  wire logic [2:0] qos_pri,
  input  wire logic [1:0] map_mode,
  input  wire logic [4:0] entry_map,
  input  wire logic [4:0] lut_map,
  output logic      [2:0] pri_out,
  output logic      [4:0] map_out
);
  always_comb begin
    unique case (aclact_pmode_type'(pmode))
      ACLACT_KEEP:   pri_out = qos_pri;
      ACLACT_HIGHER: pri_out = (entry_pri > qos_pri) ? entry_pri : qos_pri;
      ACLACT_LOWER:  pri_out = (entry_pri < qos_pri) ? entry_pri : qos_pri;
      ACLACT_FORCE:  pri_out = entry_pri;
    endcase
  end
  always_comb begin
    unique case (map_mode)
      2'b00: map_out = lut_map;
      2'b01: map_out = entry_map | lut_map;
      2'b10: map_out = entry_map & lut_map;
      2'b11: map_out = entry_map;
    endcase
  end
endmodule // aclact_prio

/* rtl/aclact_tick.sv */
// Purpose: microsecond and millisecond tick generator
// Assumes: clock rate from package
// Notes: ticks are one-cycle pulses
`timescale 1ns/1ps
module aclact_tick
  import aclact_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      us_tick,
  output logic      ms_tick
);
  logic [15:0] us_cnt_r;
  logic [15:0] ms_cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      us_cnt_r <= 16'h0000;
    end else if (us_cnt_r == 16'(US_CYCLES - 1)) begin
      us_cnt_r <= 16'h0000;
    end else begin
      us_cnt_r <= us_cnt_r + 16'h0001;
    end
  end
  assign us_tick = (us_cnt_r == 16'(US_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 16'h0000;
    end else if (us_tick) begin
      ms_cnt_r <= (ms_cnt_r == 16'(MS_PER_US - 1)) ? 16'h0000 : ms_cnt_r + 16'h0001;
    end
  end
  assign ms_tick = us_tick && (ms_cnt_r == 16'(MS_PER_US - 1));
endmodule // aclact_tick

/* testbench/acl_action_rule_set_tb.sv */
// Purpose: self-checking bench for the acl action bytes, cascade mask and count action
// Assumes: 200 MHz clock, us tick of 200 cycles, ms unit too slow to run here
// Notes: drivers queue expectations, a watcher compares them at the falling edge
`timescale 1ns/1ps
module acl_action_rule_set_tb;
  import aclact_pkg::*;
  logic        clock, resetn, data_wr, pkt_valid, pkt_match, remark_en_out, flag;
  logic [7:0]  table_sel, offset, data_in, data_out, b0, b1, m0, m1, ts;
  logic [2:0]  pkt_port, qos_pri, pri_out, remark_value_out, ep;
  logic [1:0]  rule_kind_select, entry_match_select;
  logic [4:0]  lut_map, map_out, count_irq, fw;
  logic [15:0] cascade_group_mask;
  int          mismatches, total_checks, seed, n, p;
  int          q_sel[$];
  logic [15:0] q_exp[$];

  aclact_top u_dut (.CLOCK(clock), .RESETN(resetn), .TABLE_SEL(table_sel), .OFFSET(offset),
    .DATA_WR(data_wr), .DATA_IN(data_in), .DATA_OUT(data_out), .PKT_PORT(pkt_port),
    .PKT_VALID(pkt_valid), .PKT_MATCH(pkt_match), .RULE_KIND_SELECT(rule_kind_select),
    .ENTRY_MATCH_SELECT(entry_match_select), .QOS_PRI(qos_pri), .LUT_MAP(lut_map),
    .PRI_OUT(pri_out), .REMARK_EN_OUT(remark_en_out), .REMARK_VALUE_OUT(remark_value_out),
    .MAP_OUT(map_out), .CASCADE_GROUP_MASK(cascade_group_mask), .COUNT_IRQ(count_irq));

  // ==========================================================
  // checking
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic note(input int s, input logic [15:0] e);
    q_sel.push_back(s);
    q_exp.push_back(e);
  endtask

  initial forever begin
    logic [15:0] v;
    @(negedge clock);
    while (q_sel.size() > 0) begin
      case (q_sel[0])
        0: v = {8'h00, data_out};
        1: v = {13'h0000, pri_out};
        2: v = {11'h000, map_out};
        3: v = {15'h0000, remark_en_out};
        4: v = {13'h0000, remark_value_out};
        5: v = cascade_group_mask;
        6: v = {11'h000, count_irq};
        default: v = {15'h0000, flag};
      endcase
      chk(v, q_exp.pop_front());
      void'(q_sel.pop_front());
    end
  end

  task automatic tally_and_finish;
    @(posedge clock);
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // drivers
  task automatic wr(input logic [7:0] t, input logic [7:0] off, input logic [7:0] d);
    @(posedge clock);
    table_sel <= t;
    offset    <= off;
    data_in   <= d;
    data_wr   <= 1'b1;
    @(posedge clock);
    data_wr   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] t, input logic [7:0] off, input logic [7:0] e);
    @(posedge clock);
    table_sel <= t;
    offset    <= off;
    @(posedge clock);
    note(0, {8'h00, e});
    @(negedge clock);
  endtask

  task automatic pkt;
    @(posedge clock);
    pkt_valid <= 1'b1;
    pkt_match <= 1'b1;
    @(posedge clock);
    pkt_valid <= 1'b0;
    pkt_match <= 1'b0;
  endtask

  task automatic wait_irq(input int lo, input int hi);
    n = 0;
    #1;
    while (count_irq === 5'h00 && n < 1000) begin
      @(posedge clock);
      #1;
      n++;
    end
    flag = (n >= lo && n <= hi);
    note(6, 16'h0002);
    note(7, 16'h0001);
    @(negedge clock);
  endtask

  // ==========================================================
  // stimulus
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    tally_and_finish;
  end

  initial begin
    seed = 78;
    {resetn, data_wr, pkt_valid, pkt_match, flag} = '0;
    {table_sel, offset, data_in, pkt_port, qos_pri, lut_map} = '0;
    {rule_kind_select, entry_match_select} = '0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    for (int k = 10; k < 14; k++) rd(8'h41, 8'(k), 8'h00);
    wr(8'h21, 8'h0c, 8'h5a);
    wr(8'h40, 8'h0c, 8'h5a);
    wr(8'h41, 8'h05, 8'h5a);
    rd(8'h41, 8'h0c, 8'h00);
    rd(8'h41, 8'h05, 8'h00);
    rd(8'h21, 8'h0c, 8'h00);
    $display("test register access done");
    for (int i = 0; i < 8; i++) begin
      p  = 1 + ($unsigned($random(seed)) % 5);
      ts = {3'h2, 1'b0, 4'(p)};
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      m0 = 8'($random(seed));
      m1 = 8'($random(seed));
      b0[7:6] = 2'(i);
      b1[6:5] = 2'(i + 1);
      wr(ts, 8'h0a, b0);
      wr(ts, 8'h0b, b1);
      wr(ts, 8'h0c, m0);
      wr(ts, 8'h0d, m1);
      pkt_port <= 3'(p - 1);
      qos_pri  <= 3'($random(seed));
      lut_map  <= 5'($random(seed));
      @(posedge clock);
      ep = b0[5:3];
      fw = b1[4:0];
      case (b0[7:6])
        2'h0: note(1, {13'h0000, qos_pri});
        2'h1: note(1, {13'h0000, (ep > qos_pri) ? ep : qos_pri});
        2'h2: note(1, {13'h0000, (ep < qos_pri) ? ep : qos_pri});
        default: note(1, {13'h0000, ep});
      endcase
      case (b1[6:5])
        2'h0: note(2, {11'h000, lut_map});
        2'h1: note(2, {11'h000, fw | lut_map});
        2'h2: note(2, {11'h000, fw & lut_map});
        default: note(2, {11'h000, fw});
      endcase
      note(3, {15'h0000, b0[2]});
      note(4, {13'h0000, b0[1:0], b1[7]});
      note(5, {m0, m1});
      @(negedge clock);
      rd(ts, 8'h0d, m1);
    end
    $display("test actions done");
    @(posedge clock);
    pkt_port           <= 3'h1;
    rule_kind_select   <= KIND_COUNT;
    entry_match_select <= MATCH_COUNT;
    wr(8'h42, 8'h0a, 8'h00);
    wr(8'h42, 8'h0b, 8'h68);
    pkt;
    pkt;
    repeat (3) @(posedge clock);
    note(6, 16'h0000);
    @(negedge clock);
    pkt;
    wait_irq(0, 3);
    wr(8'h42, 8'h0b, 8'h40);
    pkt;
    wait_irq(US_CYCLES + 1, 2 * US_CYCLES);
    $display("test count action done");
    tally_and_finish;
  end
endmodule // acl_action_rule_set_tb
